/* File: inc/lloop_pkg.sv */
// package: register map, field positions and constants of the loopback / composite clock block
// assumes: AXI4-Lite byte addressing, one 32-bit word per register
package lloop_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] LOOP_ADDR  = 8'h20;
  localparam logic [7:0] STAT_ADDR  = 8'h24;
  localparam logic [7:0] MASK_ADDR  = 8'h28;
  localparam logic [7:0] CCST_ADDR  = 8'h2C;
  localparam logic [7:0] CTRL_ADDR  = 8'h30;
  localparam logic [7:0] REG_RESET  = 8'h00;
  localparam logic [7:0] LOOP_BITS  = 8'h0C;
  localparam logic [7:0] EVT_BITS   = 8'h16;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int OC_BIT  = 1;
  localparam int CL_BIT  = 2;
  localparam int JT_BIT  = 4;
  localparam int REM_BIT = 2;
  localparam int LOC_BIT = 3;
  localparam int JAE_BIT = 0;
  localparam int EXT_BIT = 1;
  localparam int LCK_BIT = 0;
  // ************************************************************
  // composite clock and attenuator constants
  // ************************************************************
  localparam logic [2:0] CC_MARKS_LAST = 3'h7;
  localparam logic [2:0] CC_MARKS_HALF = 3'h4;
  localparam logic [4:0] CC_FRAMES_LAST = 5'h13;
  localparam logic [4:0] CC_FRAMES_HALF = 5'h0A;
  localparam int         JA_MARGIN      = 4;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;
  typedef struct packed {
    logic pos;
    logic neg;
  } ami_t;
  typedef enum logic [1:0] {
    CC_HUNT = 2'b01,
    CC_LOCK = 2'b10
  } cc_state_t;
endpackage

/* File: rtl/line_loopback_cc_decode.sv */
// design: line loopback routing, line status interrupts and composite clock decoder
// assumes: all inputs synchronous to CLK, AXI4-Lite master with one access of each kind at a time
//
// Notes on behaviour
// [RULE1] open-circuit and current-limit edges interrupt when unmasked
// [RULE2] attenuator trip interrupts only when its mask set
// [RULE3] remote loop sends received line data out
// [RULE4] remote loop: framer runs, formatter output dropped
// [RULE5] local loop feeds transmitted data to receiver
// [RULE6] local loop data uses attenuator when enabled
// [RULE7] software writes zero to unused loop bits
// [RULE8] line carries 64kHz AMI with 8kHz violations
// [RULE9] decoder supports basic and 400Hz extended formats
// [RULE10] recover 64k, derive 8k and 400 outputs
// [RULE11] trip set near FIFO limit, cleared by read
// [RULE12] open-circuit status follows transmit output detector
// [RULE13] interrupt high while unmasked event pending
`timescale 1ns/1ps
module line_loopback_cc_decode #(
  parameter int AW     = 8,
  parameter int FILL_W = 6,
  parameter int JA_LIMIT = 32
) (
  input  wire logic              CLK,
  input  wire logic              RST,
  input  wire logic              CE,
  input  wire logic              AWVALID,
  output logic                   AWREADY,
  input  wire logic [AW-1:0]     AWADDR,
  input  wire logic              WVALID,
  output logic                   WREADY,
  input  wire logic [31:0]       WDATA,
  input  wire logic [3:0]        WSTRB,
  output logic                   BVALID,
  input  wire logic              BREADY,
  output logic [1:0]             BRESP,
  input  wire logic              ARVALID,
  output logic                   ARREADY,
  input  wire logic [AW-1:0]     ARADDR,
  output logic                   RVALID,
  input  wire logic              RREADY,
  output logic [31:0]            RDATA,
  output logic [1:0]             RRESP,
  input  wire logic              RX_LINE_POS,
  input  wire logic              RX_LINE_NEG,
  input  wire logic              FMT_POS,
  input  wire logic              FMT_NEG,
  input  wire logic              JA_OUT_POS,
  input  wire logic              JA_OUT_NEG,
  input  wire logic [FILL_W-1:0] JA_FILL,
  input  wire logic              TX_OPEN_DET,
  input  wire logic              TX_CURLIM_DET,
  output logic                   TX_LINE_POS,
  output logic                   TX_LINE_NEG,
  output logic                   JA_IN_POS,
  output logic                   JA_IN_NEG,
  output logic                   FRM_POS,
  output logic                   FRM_NEG,
  output logic                   INT,
  output logic                   CC_64K,
  output logic                   CC_8K,
  output logic                   CC_400
);
  // ************************************************************
  // register decode
  // ************************************************************
  function automatic logic is_mapped(input logic [AW-1:0] a);
    is_mapped = (a[7:0] == lloop_pkg::LOOP_ADDR) || (a[7:0] == lloop_pkg::STAT_ADDR) ||
                (a[7:0] == lloop_pkg::MASK_ADDR) || (a[7:0] == lloop_pkg::CCST_ADDR) ||
                (a[7:0] == lloop_pkg::CTRL_ADDR);
  endfunction

  logic [7:0] loop_q, mask_q, ctrl_q, stat_q, stat_d, set_w;
  logic       oc_prev_q, cl_prev_q, trip_prev_q;
  logic       aw_go_w, ar_go_w, wr_fire_w, rd_fire_w, wr_lane_w, rd_stat_w;
  logic [7:0] rd_byte_w;
  logic       rem_w, loc_w, jae_w, ext_w, trip_w, int_d;

  assign aw_go_w   = AWVALID && WVALID && !AWREADY && !BVALID;
  assign ar_go_w   = ARVALID && !ARREADY && !RVALID;
  assign wr_fire_w = AWREADY && AWVALID && WREADY && WVALID;
  assign rd_fire_w = ARREADY && ARVALID;
  assign wr_lane_w = wr_fire_w && WSTRB[0] && is_mapped(AWADDR);
  assign rd_stat_w = rd_fire_w && (ARADDR[7:0] == lloop_pkg::STAT_ADDR);
  assign rem_w     = loop_q[lloop_pkg::REM_BIT];
  assign loc_w     = loop_q[lloop_pkg::LOC_BIT];
  assign jae_w     = ctrl_q[lloop_pkg::JAE_BIT];
  assign ext_w     = ctrl_q[lloop_pkg::EXT_BIT];

  // ************************************************************
  // line routing
  // ************************************************************
  lloop_pkg::ami_t rx_w, fmt_w, jao_w, tx_sel_w, pre_ja_w, frm_sel_w, frm_q;
  assign rx_w      = '{pos: RX_LINE_POS, neg: RX_LINE_NEG};
  assign fmt_w     = '{pos: FMT_POS, neg: FMT_NEG};
  assign jao_w     = '{pos: JA_OUT_POS, neg: JA_OUT_NEG};
  assign tx_sel_w  = rem_w ? rx_w : fmt_w;         // [RULE3] [RULE4]
  assign pre_ja_w  = loc_w ? tx_sel_w : rx_w;      // [RULE5]
  assign frm_sel_w = jae_w ? jao_w : pre_ja_w;     // [RULE6]

  always_ff @(posedge CLK) begin
    if (RST) begin
      {TX_LINE_POS, TX_LINE_NEG} <= 2'h0;
      {JA_IN_POS, JA_IN_NEG}     <= 2'h0;
      frm_q                      <= '0;
    end else if (CE) begin
      {TX_LINE_POS, TX_LINE_NEG} <= tx_sel_w;
      {JA_IN_POS, JA_IN_NEG}     <= pre_ja_w;
      frm_q                      <= frm_sel_w;
    end
  end
  assign FRM_POS = frm_q.pos;
  assign FRM_NEG = frm_q.neg;

  // ************************************************************
  // status events and interrupt
  // ************************************************************
  assign trip_w = JA_FILL >= FILL_W'(JA_LIMIT - lloop_pkg::JA_MARGIN);
  always_comb begin
    set_w                     = 8'h00;
    set_w[lloop_pkg::OC_BIT]  = TX_OPEN_DET ^ oc_prev_q;      // [RULE1] [RULE12]
    set_w[lloop_pkg::CL_BIT]  = TX_CURLIM_DET ^ cl_prev_q;    // [RULE1]
    set_w[lloop_pkg::JT_BIT]  = trip_w && !trip_prev_q;       // [RULE11]
  end
  // a set arriving with the clearing read wins
  assign stat_d = (rd_stat_w ? 8'h00 : stat_q) | set_w;       // [RULE11]
  assign int_d  = |(stat_d & (wr_lane_w && AWADDR[7:0] == lloop_pkg::MASK_ADDR ?
                  WDATA[7:0] & lloop_pkg::EVT_BITS : mask_q)); // [RULE1] [RULE2] [RULE13]

  always_ff @(posedge CLK) begin
    if (RST) begin
      stat_q      <= lloop_pkg::REG_RESET;
      oc_prev_q   <= 1'b0;
      cl_prev_q   <= 1'b0;
      trip_prev_q <= 1'b0;
      INT         <= 1'b0;
    end else if (CE) begin
      stat_q      <= stat_d;
      oc_prev_q   <= TX_OPEN_DET;
      cl_prev_q   <= TX_CURLIM_DET;
      trip_prev_q <= trip_w;
      INT         <= int_d;
    end
  end

  // ************************************************************
  // composite clock decoder
  // ************************************************************
  lloop_pkg::cc_state_t st_q, st_d;
  logic       mark_w, mark_prev_q, onset_w, last_pol_q, have_pol_q, viol_w, miss_w, miss_prev_q;
  logic [2:0] cnt_q, cnt_d;
  logic [4:0] fr_q, fr_d;
  logic       bound_w, lock_d;

  assign mark_w  = frm_q.pos | frm_q.neg;
  assign onset_w = mark_w && !mark_prev_q;
  // same polarity as the previous mark is a bipolar violation
  assign viol_w  = onset_w && have_pol_q && (frm_q.pos == last_pol_q);   // [RULE8] [RULE10]
  assign miss_w  = onset_w && !viol_w && (cnt_q == lloop_pkg::CC_MARKS_LAST) && (st_q == lloop_pkg::CC_LOCK);
  assign bound_w = viol_w || miss_w;
  assign cnt_d   = !onset_w ? cnt_q : bound_w ? 3'h0 : cnt_q + 3'h1;
  assign fr_d    = (miss_w && ext_w) || (bound_w && fr_q == lloop_pkg::CC_FRAMES_LAST) ? 5'h00 :
                   bound_w ? fr_q + 5'h01 : fr_q;                         // [RULE9]
  assign lock_d  = (st_d == lloop_pkg::CC_LOCK);

  always_comb begin
    case (st_q)
      lloop_pkg::CC_HUNT: st_d = viol_w ? lloop_pkg::CC_LOCK : lloop_pkg::CC_HUNT;
      // basic format tolerates no missing violation, extended only isolated ones
      lloop_pkg::CC_LOCK: st_d = (miss_w && (!ext_w || miss_prev_q)) ? lloop_pkg::CC_HUNT :
                                 lloop_pkg::CC_LOCK;                     // [RULE9]
      default:            st_d = lloop_pkg::CC_HUNT;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st_q        <= lloop_pkg::CC_HUNT;
      mark_prev_q <= 1'b0;
      last_pol_q  <= 1'b0;
      have_pol_q  <= 1'b0;
      miss_prev_q <= 1'b0;
      cnt_q       <= 3'h0;
      fr_q        <= 5'h00;
      CC_64K      <= 1'b0;
      CC_8K       <= 1'b0;
      CC_400      <= 1'b0;
    end else if (CE) begin
      st_q        <= st_d;
      mark_prev_q <= mark_w;
      cnt_q       <= cnt_d;
      fr_q        <= fr_d;
      if (onset_w) begin
        last_pol_q <= frm_q.pos;
        have_pol_q <= 1'b1;
      end
      if (bound_w) begin
        miss_prev_q <= miss_w;
      end
      CC_64K      <= mark_w;                                             // [RULE10]
      CC_8K       <= lock_d && (cnt_d < lloop_pkg::CC_MARKS_HALF);        // [RULE10]
      CC_400      <= lock_d && ext_w && (fr_d < lloop_pkg::CC_FRAMES_HALF); // [RULE9] [RULE10]
    end
  end

  // ************************************************************
  // AXI4-Lite slave
  // ************************************************************
  always_comb begin
    case (ARADDR[7:0])
      lloop_pkg::LOOP_ADDR: rd_byte_w = loop_q;
      lloop_pkg::STAT_ADDR: rd_byte_w = stat_q;
      lloop_pkg::MASK_ADDR: rd_byte_w = mask_q;
      lloop_pkg::CCST_ADDR: rd_byte_w = {4'h0, trip_w, TX_CURLIM_DET, TX_OPEN_DET,
                                         st_q == lloop_pkg::CC_LOCK};
      lloop_pkg::CTRL_ADDR: rd_byte_w = ctrl_q;
      default:              rd_byte_w = 8'h00;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      AWREADY <= 1'b0;
      WREADY  <= 1'b0;
      BVALID  <= 1'b0;
      BRESP   <= lloop_pkg::RESP_OKAY;
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= 32'h0000_0000;
      RRESP   <= lloop_pkg::RESP_OKAY;
      loop_q  <= lloop_pkg::REG_RESET;
      mask_q  <= lloop_pkg::REG_RESET;
      ctrl_q  <= lloop_pkg::REG_RESET;
    end else if (CE) begin
      AWREADY <= aw_go_w;
      WREADY  <= aw_go_w;
      ARREADY <= ar_go_w;
      if (wr_fire_w) begin
        BVALID <= 1'b1;
        BRESP  <= is_mapped(AWADDR) ? lloop_pkg::RESP_OKAY : lloop_pkg::RESP_SLVERR;
      end else if (BREADY) begin
        BVALID <= 1'b0;
      end
      if (rd_fire_w) begin
        RVALID <= 1'b1;
        RDATA  <= {24'h00_0000, rd_byte_w};
        RRESP  <= is_mapped(ARADDR) ? lloop_pkg::RESP_OKAY : lloop_pkg::RESP_SLVERR;
      end else if (RREADY) begin
        RVALID <= 1'b0;
      end
      if (wr_lane_w) begin
        case (AWADDR[7:0])
          // only the two loop bits are held, the rest read back as zero
          lloop_pkg::LOOP_ADDR: loop_q <= WDATA[7:0] & lloop_pkg::LOOP_BITS;
          lloop_pkg::MASK_ADDR: mask_q <= WDATA[7:0] & lloop_pkg::EVT_BITS;
          lloop_pkg::CTRL_ADDR: ctrl_q <= {6'h00, WDATA[1:0]};
          default:              ctrl_q <= ctrl_q;
        endcase
      end
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_viol_locked;
    CE && viol_w && (st_q == lloop_pkg::CC_LOCK);
  endsequence
  sequence s_first_miss;
    CE && miss_w && ext_w && !miss_prev_q;
  endsequence

  a_remote_loop_tx: assert property ((CE && rem_w) |=> (TX_LINE_POS == $past(RX_LINE_POS)) && // [RULE3]
                                     (TX_LINE_NEG == $past(RX_LINE_NEG)))
    else $error("remote loop did not send line data");
  a_formatter_path: assert property ((CE && !rem_w) |=> TX_LINE_POS == $past(FMT_POS)) // [RULE4]
    else $error("formatter data not sent");
  a_local_loop_rx: assert property ((CE && loc_w && !jae_w) |=> FRM_POS == $past(tx_sel_w.pos)) // [RULE5]
    else $error("local loop did not feed receiver");
  a_ja_route_sel: assert property ((CE && jae_w) |=> (FRM_NEG == $past(JA_OUT_NEG)) && // [RULE6]
                                   (JA_IN_POS == $past(pre_ja_w.pos)))
    else $error("attenuator path not used");
  a_oc_edge_set: assert property ((CE && (TX_OPEN_DET != oc_prev_q)) |=> stat_q[lloop_pkg::OC_BIT]) // [RULE1]
    else $error("open-circuit edge not latched");
  a_int_level: assert property (INT == |(stat_q & mask_q)) // [RULE13]
    else $error("interrupt does not follow masked status");
  a_trip_set: assert property ((CE && trip_w && !trip_prev_q) |=> stat_q[lloop_pkg::JT_BIT]) // [RULE11]
    else $error("trip event not latched");
  a_read_clear: assert property ((CE && rd_stat_w && set_w == 8'h00) |=> stat_q == 8'h00) // [RULE11]
    else $error("status read did not clear");
  a_cc_8k_phase: assert property (s_viol_locked |=> CC_8K ##1 (CC_8K || !CE)) // [RULE10]
    else $error("8k output not aligned to violation");
  a_cc_400_phase: assert property (s_first_miss |=> CC_400) // [RULE9]
    else $error("400 output not aligned to missing violation");
  a_cc_basic_loss: assert property ((CE && miss_w && !ext_w) |=> st_q == lloop_pkg::CC_HUNT) // [RULE9]
    else $error("basic format kept lock on missing violation");
  a_cc_64k_rec: assert property (CE |=> CC_64K == $past(mark_w)) // [RULE10]
    else $error("64k clock not recovered");
endmodule // line_loopback_cc_decode

/* File: tb/cc_line_model.sv */
// partner: far-end composite clock source on the receive rails
// assumes: one mark per 4 clocks, rails idle low between marks
`timescale 1ns/1ps
module cc_line_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ext,
  output logic      pos,
  output logic      neg
);
  // ****************************************
  // ami marks, 8th mark repeats polarity
  // ****************************************
  logic [1:0] ph_q;
  logic [2:0] mk_q;
  logic [4:0] fr_q;
  logic       pol_q;
  logic       viol;
  logic       p_d;
  // extended format drops the violation once per 20 frames
  assign viol = (mk_q == 3'h7) && !(ext && fr_q == 5'h13);
  assign p_d  = viol ? pol_q : !pol_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      {ph_q, mk_q, fr_q, pol_q, pos, neg} <= '0;
    end else begin
      ph_q <= ph_q + 2'h1;
      pos  <= (ph_q == 2'h0) && p_d;
      neg  <= (ph_q == 2'h0) && !p_d;
      if (ph_q == 2'h0) begin
        pol_q <= p_d;
        mk_q  <= mk_q + 3'h1;
        fr_q  <= (mk_q != 3'h7) ? fr_q : (fr_q == 5'h13) ? 5'h00 : fr_q + 5'h01;
      end
    end
  end
endmodule // cc_line_model

/* File: tb/line_loopback_cc_decode_tb.sv */
// testbench: registers, loopback routing, interrupts and composite clock decode
// assumes: design parameter defaults, line model on the receive rails
`timescale 1ns/1ps
module line_loopback_cc_decode_tb;
  logic        clk = 1'b0, rst = 1'b1, ext = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic        fp = 1'b0, fn = 1'b0, jp = 1'b0, jn = 1'b0, od = 1'b0, cd = 1'b0;
  logic [5:0]  fill = 6'h00;
  logic        aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, rxp, rxn, txp, txn;
  logic        jip, jin, frp, frn, irq, c64, c8, c4;
  logic [1:0]  b_resp, r_resp, rs;
  logic [31:0] r_data, d;
  int          num_errors = 0, tests_run = 0, cyc = 0, h8, h4;
  logic [7:0]  adr [4] = '{8'h20, 8'h24, 8'h28, 8'h30};

  always #2 clk = ~clk;

  cc_line_model u_line (.clk(clk), .rst(rst), .ext(ext), .pos(rxp), .neg(rxn));

  line_loopback_cc_decode u_dut (
    .CLK(clk), .RST(rst), .CE(1'b1), .AWVALID(awv), .AWREADY(aw_rdy), .AWADDR(awa),
    .WVALID(wv), .WREADY(w_rdy), .WDATA(wd), .WSTRB(4'hF), .BVALID(b_vld), .BREADY(bry),
    .BRESP(b_resp), .ARVALID(arv), .ARREADY(ar_rdy), .ARADDR(ara), .RVALID(r_vld),
    .RREADY(rry), .RDATA(r_data), .RRESP(r_resp), .RX_LINE_POS(rxp), .RX_LINE_NEG(rxn),
    .FMT_POS(fp), .FMT_NEG(fn), .JA_OUT_POS(jp), .JA_OUT_NEG(jn), .JA_FILL(fill),
    .TX_OPEN_DET(od), .TX_CURLIM_DET(cd), .TX_LINE_POS(txp), .TX_LINE_NEG(txn),
    .JA_IN_POS(jip), .JA_IN_NEG(jin), .FRM_POS(frp), .FRM_NEG(frn), .INT(irq),
    .CC_64K(c64), .CC_8K(c8), .CC_400(c4));

  // ****************************************
  // bus cycles and compares
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    @(posedge clk);
    awv <= 1'b1;
    wv  <= 1'b1;
    awa <= a;
    wd  <= v;
    bry <= 1'b1;
    do @(posedge clk); while (aw_rdy !== 1'b1);
    awv <= 1'b0;
    wv  <= 1'b0;
    do @(posedge clk); while (b_vld !== 1'b1);
    r = b_resp;
    bry <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rry <= 1'b1;
    do @(posedge clk); while (ar_rdy !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (r_vld !== 1'b1);
    v = r_data;
    r = r_resp;
    rry <= 1'b0;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // loop routing with the far end running and formatter/attenuator toggling
  task automatic line_run(input logic [7:0] lb, input logic [7:0] ctl);
    logic [1:0] rx, fm, ja, tx, js;
    wr(8'h20, {24'h0, lb}, rs);
    wr(8'h30, {24'h0, ctl}, rs);
    repeat (3) @(posedge clk);
    for (int i = 0; i < 24; i++) begin
      @(posedge clk);
      rx = {rxp, rxn};
      fm = {fp, fn};
      ja = {jp, jn};
      fp <= i[0] & i[1];
      fn <= i[0] & !i[1];
      jp <= i[2] & !i[0];
      jn <= i[1] & i[0];
      tx = lb[2] ? rx : fm;
      js = lb[3] ? tx : rx;
      #1;
      chk_pin({txp, txn}, tx);
      chk_pin({jip, jin}, js);
      chk_pin({frp, frn}, ctl[0] ? ja : js);
    end
  endtask

  // k selects open-circuit, current-limit or attenuator fill event
  task automatic evt(input int k, input logic [7:0] msk);
    logic [7:0] b;
    b = (k == 0) ? 8'h02 : (k == 1) ? 8'h04 : 8'h10;
    wr(8'h28, {24'h0, msk}, rs);
    @(posedge clk);
    if (k == 0) od <= !od;
    else if (k == 1) cd <= !cd;
    else fill <= (fill == 6'h00) ? 6'h1C : 6'h00;
    repeat (4) @(posedge clk);
    #1;
    if (k == 2 && fill == 6'h00) b = 8'h00;
    chk_pin({1'b0, irq}, {1'b0, |(b & msk)});
    rd(8'h24, d, rs);
    chk_word(d, {24'h0, b});
    repeat (2) @(posedge clk);
    #1;
    chk_pin({1'b0, irq}, 2'h0);
  endtask

  task automatic cc_run(input int n);
    logic f;
    h8 = 0;
    h4 = 0;
    repeat (n) begin
      @(posedge clk);
      f = frp | frn;
      #1;
      chk_pin({1'b0, c64}, {1'b0, f});
      h8 += (c8 === 1'b1);
      h4 += (c4 === 1'b1);
    end
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    foreach (adr[i]) begin
      rd(adr[i], d, rs);
      chk_word(d, 32'h0000_0000);
      chk_pin(rs, 2'h0);
    end
    rd(8'h3C, d, rs);
    chk_word(d, 32'h0000_0000);
    chk_pin(rs, 2'h2);
    wr(8'h3C, 32'h0000_00FF, rs);
    chk_pin(rs, 2'h2);
    wr(8'h20, 32'h0000_000C, rs);
    rd(8'h20, d, rs);
    chk_word(d, 32'h0000_000C);
    for (int m = 0; m < 8; m++) line_run({4'h0, m[1:0], 2'h0}, {7'h0, m[2]});
    for (int r = 0; r < 4; r++) begin
      for (int k = 0; k < 3; k++) evt(k, r[1] ? 8'h00 : 8'h16);
    end
    wr(8'h20, 32'h0000_0000, rs);
    wr(8'h30, 32'h0000_0000, rs);
    repeat (256) @(posedge clk);
    cc_run(320);
    chk_word(32'(h8), 32'h0000_00A0);
    chk_word(32'(h4), 32'h0000_0000);
    rd(8'h2C, d, rs);
    chk_word(d & 32'h0000_0001, 32'h0000_0001);
    ext <= 1'b1;
    wr(8'h30, 32'h0000_0002, rs);
    repeat (700) @(posedge clk);
    cc_run(640);
    chk_word(32'(h4), 32'h0000_0140);
    chk_word(32'(h8), 32'h0000_0140);
    // basic decoding of an extended line: each missing violation costs one 8k pulse
    wr(8'h30, 32'h0000_0000, rs);
    repeat (700) @(posedge clk);
    cc_run(640);
    chk_word(32'(h8), 32'h0000_0130);
    chk_word(32'(h4), 32'h0000_0000);
    end_of_test();
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      num_errors++;
      end_of_test();
    end
  end
endmodule // line_loopback_cc_decode_tb
